//--- hdl/servo_consts.svh
// Named constants of the step/direction front end and fault lamp.
`ifndef SERVO_CONSTS_SVH
`define SERVO_CONSTS_SVH

// ==========================================================================
// Register byte offsets
`define ADDR_GEAR_NUM      8'h00
`define ADDR_GEAR_DEN      8'h04
`define ADDR_FOLLOW_LIMIT  8'h08
`define ADDR_POSITION      8'h0C
`define ADDR_FAULT_STATE   8'h10
`define ADDR_INT_STATUS    8'h14
`define ADDR_INT_MASK      8'h18

// ==========================================================================
// Reset values
`define GEAR_NUM_RST       16'h0001
`define GEAR_DEN_RST       16'h0001
`define FOLLOW_LIMIT_RST   16'hFFFF
`define INT_MASK_RST       5'h00
`define INT_STATUS_RST     5'h00
`define POSITION_RST       32'h00000000
`define PEND_RST           20'sh00000

// ==========================================================================
// Fault bit positions in the raw, status and mask fields
`define FLT_OVER_CURRENT   0
`define FLT_OVER_VOLTAGE   1
`define FLT_PHASE          2
`define FLT_ENCODER        3
`define FLT_FOLLOW         4

// ==========================================================================
// Lamp flash counts per display period
`define BLINKS_NONE        4'h0
`define BLINKS_OC          4'h1
`define BLINKS_OV          4'h2
`define BLINKS_PHASE       4'h4
`define BLINKS_ENCODER     4'h5
`define BLINKS_FOLLOW      4'h7

// ==========================================================================
// Timing
`define CLK_KHZ            32'd125000
`define FAULT_PERIOD_MS    32'd5000
`define BLINK_SLOT_MS      32'd250

// ==========================================================================
// AXI responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

//--- hdl/servo_pkg.sv
// Types shared by the servo command front end and the fault lamp blinker.
package servo_pkg;

  // ========================================================================
  // Displayed fault, in falling priority order
  typedef enum logic [2:0] {
    FAULT_NONE         = 3'b000,
    FAULT_OVER_CURRENT = 3'b001,
    FAULT_OVER_VOLTAGE = 3'b010,
    FAULT_PHASE        = 3'b011,
    FAULT_ENCODER      = 3'b100,
    FAULT_FOLLOW       = 3'b101
  } fault_code_t;

  // ========================================================================
  // State of the top module
  typedef struct packed {
    logic aw_held;
    logic [7:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] gear_num;
    logic [15:0] gear_den;
    logic [15:0] follow_limit;
    logic [4:0] int_status;
    logic [4:0] int_mask;
    logic irq;
    logic step_s1;
    logic step_s2;
    logic step_s3;
    logic dir_s1;
    logic dir_s2;
    logic en_s1;
    logic en_s2;
    logic motor_cw;
    logic signed [19:0] pend;
    logic [31:0] pos;
    logic [4:0] fault_raw;
    fault_code_t code;
    logic lamp;
  } core_state_t;

  // ========================================================================
  // State of the lamp blinker
  typedef struct packed {
    logic [31:0] period_cnt;
    logic [31:0] slot_cnt;
    logic [4:0] slot_idx;
    logic [3:0] blinks;
    logic lamp;
  } blink_state_t;

endpackage : servo_pkg

//--- hdl/fault_lamp_if.sv
// Interface between the fault priority logic and the lamp blinker.
`timescale 1ns/100ps
interface fault_lamp_if;
  servo_pkg::fault_code_t code;
  logic lamp;
  modport src (output code, input lamp);
  modport blink (input code, output lamp);
endinterface : fault_lamp_if

//--- hdl/fault_lamp_blinker.sv
// Fault lamp blinker: flashes a coded count inside a repeating period.
`timescale 1ns/100ps
`include "servo_consts.svh"
module fault_lamp_blinker #(
  parameter logic [31:0] PERIOD_CYC = `FAULT_PERIOD_MS * `CLK_KHZ,
  parameter logic [31:0] SLOT_CYC = `BLINK_SLOT_MS * `CLK_KHZ
) (
  input wire logic aclk,
  input wire logic aresetn,
  fault_lamp_if.blink bus
);
  import servo_pkg::*;

  blink_state_t s;
  blink_state_t n;
  logic restart;

  function automatic logic [3:0] blinks_of(input fault_code_t c);
    unique case (c)
      FAULT_NONE: blinks_of = `BLINKS_NONE;
      FAULT_OVER_CURRENT: blinks_of = `BLINKS_OC;
      FAULT_OVER_VOLTAGE: blinks_of = `BLINKS_OV;
      FAULT_PHASE: blinks_of = `BLINKS_PHASE;
      FAULT_ENCODER: blinks_of = `BLINKS_ENCODER;
      FAULT_FOLLOW: blinks_of = `BLINKS_FOLLOW;
      default: blinks_of = `BLINKS_NONE;
    endcase
  endfunction : blinks_of

  // ========================================================================
  // Period and slot sequencing
  // The count is latched per period so a pattern is never cut mid-way; an
  // idle lamp restarts at once so a new fault shows without a 5 s wait.
  always_comb begin
    n = s;
    restart = (s.period_cnt == PERIOD_CYC - 32'd1) ||
              (s.blinks == `BLINKS_NONE && bus.code != FAULT_NONE);
    if (restart) begin
      n.period_cnt = 32'd0;
      n.slot_cnt = 32'd0;
      n.slot_idx = 5'd0;
      n.blinks = blinks_of(bus.code);
    end else begin
      n.period_cnt = s.period_cnt + 32'd1;
      if (s.slot_cnt == SLOT_CYC - 32'd1) begin
        n.slot_cnt = 32'd0;
        if (s.slot_idx != 5'h1F) begin
          n.slot_idx = s.slot_idx + 5'd1;
        end
      end else begin
        n.slot_cnt = s.slot_cnt + 32'd1;
      end
    end
    // Even slots below twice the latched count are lit, odd slots are the dark gaps between flashes.
    n.lamp = !n.slot_idx[0] && (n.slot_idx[4:1] < n.blinks);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign bus.lamp = s.lamp;

  // ========================================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_restart;
    (s.period_cnt == PERIOD_CYC - 32'd1) ||
    (s.blinks == `BLINKS_NONE && bus.code != FAULT_NONE);
  endsequence

  property p_dark_when_clear;
    (s.blinks == `BLINKS_NONE && bus.code == FAULT_NONE) |=> !bus.lamp;
  endproperty
  a_dark_when_clear: assert property (p_dark_when_clear)
    else $error("Lamp lit with no fault latched.");

  property p_oc_blinks;
    s_restart ##0 (bus.code == FAULT_OVER_CURRENT) |=> (s.blinks == `BLINKS_OC) && bus.lamp;
  endproperty
  a_oc_blinks: assert property (p_oc_blinks)
    else $error("Over-current period does not start with one flash.");

  property p_ov_blinks;
    s_restart ##0 (bus.code == FAULT_OVER_VOLTAGE) |=> s.blinks == `BLINKS_OV;
  endproperty
  a_ov_blinks: assert property (p_ov_blinks)
    else $error("Over-voltage period does not latch two flashes.");

  property p_enc_blinks;
    s_restart ##0 (bus.code == FAULT_ENCODER) |=> s.blinks == `BLINKS_ENCODER;
  endproperty
  a_enc_blinks: assert property (p_enc_blinks)
    else $error("Encoder error period does not latch five flashes.");

endmodule : fault_lamp_blinker

//--- hdl/step_dir_servo_fault_indicator.sv
// Step/direction command front end, fault priority, lamp and AXI4-Lite registers.
`timescale 1ns/100ps
`include "servo_consts.svh"
module step_dir_servo_fault_indicator #(
  parameter logic [31:0] PERIOD_CYC = `FAULT_PERIOD_MS * `CLK_KHZ,
  parameter logic [31:0] SLOT_CYC = `BLINK_SLOT_MS * `CLK_KHZ
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic step_pulse_input,
  input wire logic direction_input,
  input wire logic drive_enable_pin,
  input wire logic over_current,
  input wire logic over_voltage,
  input wire logic phase_error,
  input wire logic encoder_error,
  input wire logic [15:0] following_error,
  output logic motor_cw,
  output logic [31:0] command_position,
  output servo_pkg::fault_code_t active_fault,
  output logic fault_lamp,
  output logic irq
);
  import servo_pkg::*;

  core_state_t s;
  core_state_t n;
  fault_lamp_if lamp_bus ();

  logic [4:0] clr;
  logic [4:0] evt;
  logic step_evt;
  logic [15:0] den_eff;
  logic signed [19:0] num_s;
  logic signed [19:0] den_s;
  logic signed [19:0] delta;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    merge16 = old;
    if (strb[0]) begin
      merge16[7:0] = data[7:0];
    end
    if (strb[1]) begin
      merge16[15:8] = data[15:8];
    end
  endfunction : merge16

  always_comb begin
    n = s;
    clr = 5'h00;
    evt = 5'h00;
    step_evt = 1'b0;
    delta = 20'sh00000;
    den_eff = (s.gear_den == 16'h0000) ? 16'h0001 : s.gear_den;
    num_s = signed'({4'h0, s.gear_num});
    den_s = signed'({4'h0, den_eff});

    // ======================================================================
    // AXI4-Lite write channel: address and data are taken in either order
    if (s.awready && s_axi_awvalid) begin
      n.aw_held = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s.wready && s_axi_wvalid) begin
      n.w_held = 1'b1;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (s.aw_held && s.w_held && !s.bvalid) begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `RESP_OKAY;
      case (s.aw_addr)
        `ADDR_GEAR_NUM: n.gear_num = merge16(s.gear_num, s.w_data, s.w_strb);
        `ADDR_GEAR_DEN: n.gear_den = merge16(s.gear_den, s.w_data, s.w_strb);
        `ADDR_FOLLOW_LIMIT: n.follow_limit = merge16(s.follow_limit, s.w_data, s.w_strb);
        `ADDR_INT_STATUS: begin
          if (s.w_strb[0]) begin
            clr = s.w_data[4:0];
          end
        end
        `ADDR_INT_MASK: begin
          if (s.w_strb[0]) begin
            n.int_mask = s.w_data[4:0];
          end
        end
        `ADDR_POSITION, `ADDR_FAULT_STATE: begin
          // Read-only words accept and drop the write.
        end
        default: n.bresp = `RESP_SLVERR;
      endcase
    end
    n.awready = !n.aw_held && !n.bvalid;
    n.wready = !n.w_held && !n.bvalid;

    // ======================================================================
    // AXI4-Lite read channel
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s.arready && s_axi_arvalid) begin
      n.rvalid = 1'b1;
      n.rresp = `RESP_OKAY;
      case (s_axi_araddr)
        `ADDR_GEAR_NUM: n.rdata = {16'h0000, s.gear_num};
        `ADDR_GEAR_DEN: n.rdata = {16'h0000, s.gear_den};
        `ADDR_FOLLOW_LIMIT: n.rdata = {16'h0000, s.follow_limit};
        `ADDR_POSITION: n.rdata = s.pos;
        `ADDR_FAULT_STATE: n.rdata = {24'h000000, s.fault_raw, s.code};
        `ADDR_INT_STATUS: n.rdata = {27'h0000000, s.int_status};
        `ADDR_INT_MASK: n.rdata = {27'h0000000, s.int_mask};
        default: begin
          n.rdata = 32'h00000000;
          n.rresp = `RESP_SLVERR;
        end
      endcase
    end
    n.arready = !n.rvalid;

    // ======================================================================
    // Step, direction and enable synchronisers
    n.step_s1 = step_pulse_input;
    n.step_s2 = s.step_s1;
    n.step_s3 = s.step_s2;
    n.dir_s1 = direction_input;
    n.dir_s2 = s.dir_s1;
    n.en_s1 = drive_enable_pin;
    n.en_s2 = s.en_s1;
    // Direction and step share the same synchroniser depth, so the setup the
    // controller gives ahead of the edge is preserved at the sample point.
    step_evt = s.step_s2 && !s.step_s3 && s.en_s2;
    if (step_evt) begin
      n.motor_cw = s.dir_s2;
      delta = s.dir_s2 ? num_s : -num_s;
    end

    // ======================================================================
    // Gear scaling: a fractional remainder is drained one count per clock,
    // which caps output at one count per cycle but needs no divider.
    if (s.pend >= den_s) begin
      n.pos = s.pos + 32'd1;
      delta = delta - den_s;
    end else if (s.pend <= -den_s) begin
      n.pos = s.pos - 32'd1;
      delta = delta + den_s;
    end
    n.pend = s.pend + delta;

    // ======================================================================
    // Fault capture, priority and interrupt status
    n.fault_raw[`FLT_OVER_CURRENT] = over_current;
    n.fault_raw[`FLT_OVER_VOLTAGE] = over_voltage;
    n.fault_raw[`FLT_PHASE] = phase_error;
    n.fault_raw[`FLT_ENCODER] = encoder_error;
    n.fault_raw[`FLT_FOLLOW] = (following_error >= s.follow_limit);
    if (s.fault_raw[`FLT_OVER_CURRENT]) begin
      n.code = FAULT_OVER_CURRENT;
    end else if (s.fault_raw[`FLT_OVER_VOLTAGE]) begin
      n.code = FAULT_OVER_VOLTAGE;
    end else if (s.fault_raw[`FLT_PHASE]) begin
      n.code = FAULT_PHASE;
    end else if (s.fault_raw[`FLT_ENCODER]) begin
      n.code = FAULT_ENCODER;
    end else if (s.fault_raw[`FLT_FOLLOW]) begin
      n.code = FAULT_FOLLOW;
    end else begin
      n.code = FAULT_NONE;
    end
    evt = n.fault_raw & ~s.fault_raw;
    // A fault that starts in the cycle its bit is cleared stays recorded.
    n.int_status = (s.int_status & ~clr) | evt;
    n.irq = |(s.int_status & s.int_mask);
    n.lamp = lamp_bus.lamp;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.gear_num <= `GEAR_NUM_RST;
      s.gear_den <= `GEAR_DEN_RST;
      s.follow_limit <= `FOLLOW_LIMIT_RST;
      s.int_mask <= `INT_MASK_RST;
      s.int_status <= `INT_STATUS_RST;
      s.pos <= `POSITION_RST;
      s.pend <= `PEND_RST;
      s.code <= FAULT_NONE;
    end else begin
      s <= n;
    end
  end

  assign lamp_bus.code = s.code;

  fault_lamp_blinker #(
    .PERIOD_CYC(PERIOD_CYC),
    .SLOT_CYC(SLOT_CYC)
  ) u_blinker (
    .aclk(aclk),
    .aresetn(aresetn),
    .bus(lamp_bus)
  );

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign motor_cw = s.motor_cw;
  assign command_position = s.pos;
  assign active_fault = s.code;
  assign fault_lamp = s.lamp;
  assign irq = s.irq;

  // ========================================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_oc_first;
    over_current |-> ##2 (active_fault == FAULT_OVER_CURRENT);
  endproperty
  a_oc_first: assert property (p_oc_first)
    else $error("Over-current not shown ahead of other faults.");

  property p_phase_shown;
    (phase_error && !over_current && !over_voltage) |-> ##2 (active_fault == FAULT_PHASE);
  endproperty
  a_phase_shown: assert property (p_phase_shown)
    else $error("Phase error not shown when no higher fault is active.");

  property p_follow_shown;
    (following_error >= s.follow_limit && !over_current && !over_voltage && !phase_error &&
     !encoder_error) ##1 $stable(s.follow_limit) |=> (active_fault == FAULT_FOLLOW);
  endproperty
  a_follow_shown: assert property (p_follow_shown)
    else $error("Following error at limit not shown.");

  property p_disabled_hold;
    (!drive_enable_pin) [*3] ##0 (s.pend == 20'sh00000) |=>
      (s.pend == 20'sh00000) && $stable(command_position);
  endproperty
  a_disabled_hold: assert property (p_disabled_hold)
    else $error("Position moved while the drive was disabled.");

  sequence s_step_taken;
    s.step_s2 && !s.step_s3 && s.en_s2;
  endsequence

  property p_dir_follows;
    s_step_taken |=> (motor_cw == $past(s.dir_s2));
  endproperty
  a_dir_follows: assert property (p_dir_follows)
    else $error("Motor direction does not follow the sampled direction input.");

  property p_unit_gear;
    (s_step_taken ##0 (s.dir_s2 && s.pend == 20'sh00000 && s.gear_num >= s.gear_den &&
     s.gear_den != 16'h0000)) |=> ##1 (command_position == $past(command_position, 2) + 32'd1);
  endproperty
  a_unit_gear: assert property (p_unit_gear)
    else $error("One clockwise step at a ratio of one or more did not add a count.");

  property p_irq_level;
    (|(s.int_status & s.int_mask)) |=> irq;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("Unmasked status bit did not raise the interrupt.");

  property p_set_beats_clear;
    (over_voltage && !s.fault_raw[`FLT_OVER_VOLTAGE]) |=> s.int_status[`FLT_OVER_VOLTAGE];
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear)
    else $error("Over-voltage onset not recorded in the status register.");

endmodule : step_dir_servo_fault_indicator

//--- verif/step_ctrl_model.sv
// Behavioural motion controller driving step, direction and enable.
`timescale 1ns/100ps
module step_ctrl_model #(
  parameter int SETUP_CYC = 625,
  parameter int WIDTH_CYC = 4
) (
  input wire logic aclk,
  output logic step,
  output logic dir,
  output logic en
);
  initial begin
    step = 1'b0;
    dir = 1'b0;
    en = 1'b0;
  end

  // ==========================================================================
  // Move
  // Enable settles first, then direction, so the driver never sees a late direction.
  task automatic move(input int n, input logic d, input logic e);
    @(posedge aclk);
    en <= e;
    repeat (SETUP_CYC) @(posedge aclk);
    dir <= d;
    repeat (SETUP_CYC) @(posedge aclk);
    repeat (n) begin
      step <= 1'b1;
      repeat (WIDTH_CYC) @(posedge aclk);
      step <= 1'b0;
      repeat (WIDTH_CYC) @(posedge aclk);
    end
  endtask : move
endmodule : step_ctrl_model

//--- verif/testbench.sv
// Self-checking bench for the step front end, fault lamp and registers.
`timescale 1ns/100ps
`include "servo_consts.svh"
module testbench;
  import servo_pkg::*;
  localparam int PERIOD = 200;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, command_position;
  logic step_pulse_input, direction_input, drive_enable_pin;
  logic over_current = 1'b0;
  logic over_voltage = 1'b0;
  logic phase_error = 1'b0;
  logic encoder_error = 1'b0;
  logic [15:0] following_error = 16'h0000;
  logic motor_cw, fault_lamp, irq;
  fault_code_t active_fault;
  logic [3:0] blink_tab [5] = '{`BLINKS_OC, `BLINKS_OV, `BLINKS_PHASE, `BLINKS_ENCODER,
                                `BLINKS_FOLLOW};
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;

  step_dir_servo_fault_indicator #(.PERIOD_CYC(32'd200), .SLOT_CYC(32'd10)) uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .step_pulse_input, .direction_input, .drive_enable_pin,
    .over_current, .over_voltage, .phase_error, .encoder_error, .following_error,
    .motor_cw, .command_position, .active_fault, .fault_lamp, .irq);

  step_ctrl_model ctl (.aclk(aclk), .step(step_pulse_input), .dir(direction_input),
    .en(drive_enable_pin));

  always #4 aclk = ~aclk;

  // ==========================================================================
  // Common tasks
  task automatic end_of_test();
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok = 1'b0;
    logic w_ok = 1'b0;
    logic b_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_ok) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid) begin
        b_ok = 1'b1;
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_ok = 1'b0;
    logic r_ok = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r_ok) begin
      @(posedge aclk);
      if (!ar_ok && s_axi_arready) begin
        ar_ok = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid) begin
        r_ok = 1'b1;
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
  endtask : axi_read

  task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rexp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check("rdata", d, exp);
    check("rresp", 32'(r), 32'(rexp));
  endtask : rd_check

  task automatic wr_check(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rexp);
    logic [1:0] r;
    axi_write(a, d, r);
    check("bresp", 32'(r), 32'(rexp));
  endtask : wr_check

  // The follow bit drives the error exactly to the limit, otherwise one below it.
  task automatic set_faults(input logic [4:0] f);
    @(posedge aclk);
    over_current <= f[0];
    over_voltage <= f[1];
    phase_error <= f[2];
    encoder_error <= f[3];
    following_error <= f[4] ? 16'h0100 : 16'h00FF;
  endtask : set_faults

  // Any window of exactly one period holds each flash of the pattern once.
  task automatic count_blinks(output int n);
    logic prev = fault_lamp;
    n = 0;
    repeat (PERIOD) begin
      @(posedge aclk);
      if (fault_lamp && !prev) n++;
      prev = fault_lamp;
    end
  endtask : count_blinks

  // ==========================================================================
  // Scenarios
  task automatic test_regs();
    rd_check(`ADDR_GEAR_NUM, 32'h00000001, `RESP_OKAY);
    rd_check(`ADDR_GEAR_DEN, 32'h00000001, `RESP_OKAY);
    rd_check(`ADDR_FOLLOW_LIMIT, 32'h0000FFFF, `RESP_OKAY);
    rd_check(`ADDR_INT_MASK, 32'h00000000, `RESP_OKAY);
    rd_check(`ADDR_INT_STATUS, 32'h00000000, `RESP_OKAY);
    rd_check(8'h1C, 32'h00000000, `RESP_SLVERR);
    wr_check(8'h1C, 32'h0000FFFF, `RESP_SLVERR);
    wr_check(`ADDR_GEAR_NUM, 32'hFFFF0003, `RESP_OKAY);
    rd_check(`ADDR_GEAR_NUM, 32'h00000003, `RESP_OKAY);
    wr_check(`ADDR_GEAR_DEN, 32'h00000002, `RESP_OKAY);
  endtask : test_regs

  task automatic test_steps();
    ctl.move(4, 1'b1, 1'b1);
    repeat (20) @(posedge aclk);
    check("motor_cw", 32'(motor_cw), 32'h00000001);
    check("position", command_position, 32'h00000006);
    ctl.move(2, 1'b0, 1'b1);
    repeat (20) @(posedge aclk);
    check("motor_cw", 32'(motor_cw), 32'h00000000);
    check("position", command_position, 32'h00000003);
    ctl.move(3, 1'b1, 1'b0);
    repeat (20) @(posedge aclk);
    check("position", command_position, 32'h00000003);
    check("motor_cw", 32'(motor_cw), 32'h00000000);
    wr_check(`ADDR_POSITION, 32'h00000055, `RESP_OKAY);
    rd_check(`ADDR_POSITION, 32'h00000003, `RESP_OKAY);
    wr_check(`ADDR_GEAR_DEN, 32'h00000000, `RESP_OKAY);
    ctl.move(1, 1'b1, 1'b1);
    repeat (20) @(posedge aclk);
    check("motor_cw", 32'(motor_cw), 32'h00000001);
    check("position", command_position, 32'h00000006);
  endtask : test_steps

  task automatic test_faults();
    logic [4:0] f;
    int n;
    wr_check(`ADDR_FOLLOW_LIMIT, 32'h00000100, `RESP_OKAY);
    for (int i = 0; i < 5; i++) begin
      f = 5'h1F << i;
      set_faults(f);
      repeat (PERIOD + 60) @(posedge aclk);
      check("active_fault", 32'(active_fault), 32'(i + 1));
      count_blinks(n);
      check("blinks", 32'(n), 32'(blink_tab[i]));
      rd_check(`ADDR_FAULT_STATE, {24'h000000, f, 3'(i + 1)}, `RESP_OKAY);
    end
    set_faults(5'h00);
    repeat (PERIOD + 60) @(posedge aclk);
    check("active_fault", 32'(active_fault), 32'h00000000);
    count_blinks(n);
    check("blinks", 32'(n), 32'h00000000);
  endtask : test_faults

  task automatic test_irq();
    rd_check(`ADDR_INT_STATUS, 32'h0000001F, `RESP_OKAY);
    check("irq", 32'(irq), 32'h00000000);
    wr_check(`ADDR_INT_MASK, 32'h00000002, `RESP_OKAY);
    repeat (3) @(posedge aclk);
    check("irq", 32'(irq), 32'h00000001);
    wr_check(`ADDR_INT_STATUS, 32'h00000002, `RESP_OKAY);
    rd_check(`ADDR_INT_STATUS, 32'h0000001D, `RESP_OKAY);
    check("irq", 32'(irq), 32'h00000000);
    set_faults(5'h02);
    repeat (5) @(posedge aclk);
    check("irq", 32'(irq), 32'h00000001);
    wr_check(`ADDR_INT_STATUS, 32'h0000001F, `RESP_OKAY);
    rd_check(`ADDR_INT_STATUS, 32'h00000000, `RESP_OKAY);
    check("irq", 32'(irq), 32'h00000000);
  endtask : test_irq

  // ==========================================================================
  // Sequence and watchdog
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 12000) begin
      num_errors++;
      end_of_test();
    end
  end

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    test_regs();
    test_steps();
    test_faults();
    test_irq();
    end_of_test();
  end
endmodule : testbench
